/* rtl/reset_irq_pkg.sv */
// shared constants for reset and interrupt control
package reset_irq_pkg;
	localparam logic [15:0] vec_reset = 16'hFFFE;
	localparam logic [15:0] vec_software = 16'hFFFC;
	localparam logic [15:0] vec_display = 16'hFFFA;
	localparam logic [15:0] vec_ext_request = 16'hFFF8;
	localparam logic [15:0] vec_timer = 16'hFFF6;
	localparam logic [15:0] vec_serial = 16'hFFF4;
	localparam logic [15:0] vec_accumulator = 16'hFFF2;
	localparam logic [15:0] vec_mft = 16'hFFF0;
	localparam logic [15:0] watchdog_service_addr = 16'hFFF0;
	localparam logic [7:0] mft_reg_addr = 8'h1C;
	localparam int watchdog_enable_pos = 2;
	localparam int watchdog_service_pos = 0;
	localparam logic [15:0] timer_counter_reset = 16'hFFFC;
	localparam logic [15:0] stack_pointer_reset = 16'h00FF;
	localparam int por_delay_tcyc = 4064;
	localparam int clock_mhz = 100;
	localparam int bus_cycle_ns = 10;
	localparam int hw_sources = 7;
	typedef enum logic [1:0] {st_por, st_hold, st_run} reset_state_e;
endpackage : reset_irq_pkg

/* rtl/pin_sync.sv */
// two-stage synchroniser for an asynchronous pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	input wire logic clock,
	input wire logic srst,
	input wire logic async_in,
	output logic sync_out
);
	typedef struct packed {
		logic first;
		logic second;
	} sync_s;
	sync_s state_reg;
	sync_s state_next;
	always_comb begin
		state_next.first = async_in;
		state_next.second = state_reg.first;
	end
	// resets to high: a released reset pin is the idle level
	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= '{first: 1'b1, second: 1'b1};
		end else begin
			state_reg <= state_next;
		end
	end
	assign sync_out = state_reg.second;
endmodule : pin_sync
`default_nettype wire

/* rtl/watchdog_timer.sv */
// operating-check watchdog: enable once, service by write, timeout pulse
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer #(
	parameter int timeout_cycles = 65536
) (
	input wire logic clock,
	input wire logic sys_reset,
	input wire logic enable_write,
	input wire logic service_write,
	output logic timeout,
	output logic enabled
);
	typedef struct packed {
		logic en;
		logic [31:0] count;
		logic fire;
	} wd_s;
	wd_s state_reg;
	wd_s state_next;
	always_comb begin
		state_next = state_reg;
		state_next.fire = 1'b0;
		if (enable_write) begin
			state_next.en = 1'b1; // sticky until reset
		end
		if (!state_reg.en || service_write) begin
			state_next.count = '0;
		end else if (state_reg.count == 32'(timeout_cycles - 1)) begin
			state_next.count = '0;
			state_next.fire = 1'b1;
		end else begin
			state_next.count = state_reg.count + 32'd1;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_reset) begin
			state_reg <= '0; // cleared and disabled
		end else begin
			state_reg <= state_next;
		end
	end
	assign timeout = state_reg.fire;
	assign enabled = state_reg.en;
endmodule : watchdog_timer
`default_nettype wire

/* rtl/reset_and_interrupt_control.sv */
// reset sequencing, default state, and interrupt arbitration
// How it works
// - power-up, reset pin or watchdog reset fetch top vector and set mask
// - after power-up hold reset for 4064 instruction cycles
// - reset pin still low at delay end keeps reset until it rises
// - only rising supply triggers power-up reset, never a falling one
// - reset sequence starts on first clock edge after pin rises; here sys_reset falls on the third edge, after the two-stage pin synchroniser
// - software writes zero to service bit or watchdog times out
// - watchdog reset keeps the operating mode active at timeout
// - watchdog off after reset, enabled by write, never disabled by software
// - reset clears prescaler, presets timer counter, clears timer enables
// - reset clears direction registers and restores ports to plain I/O
// - reset loads stack pointer, sets mask, drives vector, clears stop/wait
// - reset clears enables, watchdog and peripheral/display defaults
// - six hardware sources plus software trap; mask blocks all but trap
// - disabled source still sets flag but requests nothing
// - flags and enables never share a register
// - flag clears only after status read then associated access
// - pending unmasked source: finish, stack, set mask, fetch vector
// - return restores state; mask cleared only if stacked copy zero
// - higher vector address wins among simultaneous requests
// - vector pairs descend by two from display to multi-function timer
// - sources sharing a vector OR their flags together
`timescale 1ns/1ps
`default_nettype none
module reset_and_interrupt_control
	import reset_irq_pkg::*;
#(
	parameter int por_delay = por_delay_tcyc,
	parameter int watchdog_cycles = 65536
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic supply_rise,
	input wire logic reset_pin_n,
	input wire logic watchdog_service_write,
	input wire logic watchdog_service_data,
	input wire logic mft_write,
	input wire logic [7:0] mft_write_data,
	input wire logic [1:0] mode_pins,
	input wire logic instruction_end,
	input wire logic software_trap,
	input wire logic return_from_service,
	input wire logic stacked_mask,
	input wire logic vertical_flyback_flag,
	input wire logic row0_done_flag,
	input wire logic row1_done_flag,
	input wire logic row2_done_flag,
	input wire logic row3_done_flag,
	input wire logic display_irq_enable,
	input wire logic ext_request,
	input wire logic capture_flag,
	input wire logic compare0_flag,
	input wire logic compare1_flag,
	input wire logic counter_overflow_flag,
	input wire logic capture_irq_enable,
	input wire logic compare0_irq_enable,
	input wire logic compare1_irq_enable,
	input wire logic overflow_irq_enable,
	input wire logic arbitration_lost_flag,
	input wire logic addressed_as_target_flag,
	input wire logic transfer_complete_flag,
	input wire logic serial_irq_enable,
	input wire logic accumulator_overflow_flag,
	input wire logic accumulator_irq_enable,
	input wire logic periodic_tick_flag,
	input wire logic mft_overflow_flag,
	input wire logic periodic_irq_enable,
	input wire logic mft_overflow_irq_enable,
	output logic sys_reset,
	output logic [1:0] operating_mode,
	output logic interrupt_mask,
	output logic service_take,
	output logic [15:0] vector_address,
	output logic [15:0] stack_pointer_init,
	output logic [15:0] timer_counter_init,
	output logic watchdog_enabled,
	output logic [hw_sources-1:0] source_request
);
	localparam int tcyc_cycles = (bus_cycle_ns * clock_mhz + 999) / 1000 > 0 ?
		(bus_cycle_ns * clock_mhz + 999) / 1000 : 1;
	// the power-up delay counts instruction cycles, one tick each, not raw clocks

	typedef struct packed {
		reset_state_e st;
		logic [31:0] por_count;
		logic [31:0] tcyc_count;
		logic tcyc_tick;
		logic supply_meta;
		logic supply_seen;
		logic [1:0] mode_meta;
		logic [1:0] mode_sync;
		logic powered;
		logic mask;
		logic take;
		logic [15:0] vector;
		logic [1:0] mode;
		logic mode_latched;
	} ctl_s;
	ctl_s state_reg;
	ctl_s state_next;

	logic pin_n_sync;
	logic wd_timeout;
	logic [hw_sources-1:0] flag_group;
	logic [hw_sources-1:0] enable_group;
	logic [hw_sources-1:0] req;
	logic [15:0] win_vector;
	logic win_valid;

	pin_sync u_pin_sync (
		.clock(clock),
		.srst(srst),
		.async_in(reset_pin_n),
		.sync_out(pin_n_sync)
	);

	watchdog_timer #(
		.timeout_cycles(watchdog_cycles)
	) u_watchdog (
		.clock(clock),
		.sys_reset(sys_reset),
		.enable_write(mft_write && mft_write_data[watchdog_enable_pos]),
		.service_write(watchdog_service_write && !watchdog_service_data),
		.timeout(wd_timeout),
		.enabled(watchdog_enabled)
	);

	// index 6 is display, 1 is multi-function timer, 0 is tied off and never requests
	always_comb begin
		flag_group[6] = vertical_flyback_flag | row0_done_flag | row1_done_flag |
			row2_done_flag | row3_done_flag;
		flag_group[5] = ext_request;
		flag_group[4] = (capture_flag & capture_irq_enable) | (compare0_flag & compare0_irq_enable) |
			(compare1_flag & compare1_irq_enable) | (counter_overflow_flag & overflow_irq_enable);
		flag_group[3] = arbitration_lost_flag | addressed_as_target_flag | transfer_complete_flag;
		flag_group[2] = accumulator_overflow_flag;
		flag_group[1] = (periodic_tick_flag & periodic_irq_enable) |
			(mft_overflow_flag & mft_overflow_irq_enable);
		flag_group[0] = 1'b0;
		enable_group[6] = display_irq_enable;
		// external request has no local gate in this block
		enable_group[5] = 1'b1;
		// timer and mft flags are already gated one by one above
		enable_group[4] = 1'b1;
		enable_group[3] = serial_irq_enable;
		enable_group[2] = accumulator_irq_enable;
		enable_group[1] = 1'b1;
		enable_group[0] = 1'b0;
	end

	// flags are owned by the peripherals; this block only gates them
	genvar gi;
	generate
		for (gi = 0; gi < hw_sources; gi++) begin : g_src
			assign req[gi] = flag_group[gi] & enable_group[gi] & !sys_reset;
		end
	endgenerate
	assign source_request = req;

	// fixed priority by vector address
	always_comb begin
		win_valid = 1'b1;
		if (req[6]) begin
			win_vector = vec_display;
		end else if (req[5]) begin
			win_vector = vec_ext_request;
		end else if (req[4]) begin
			win_vector = vec_timer;
		end else if (req[3]) begin
			win_vector = vec_serial;
		end else if (req[2]) begin
			win_vector = vec_accumulator;
		end else if (req[1]) begin
			win_vector = vec_mft;
		end else begin
			win_vector = vec_reset;
			win_valid = 1'b0;
		end
	end

	always_comb begin
		state_next = state_reg;
		state_next.take = 1'b0;

		// supply detector and mode pins come from outside the clock domain
		state_next.supply_meta = supply_rise;
		state_next.supply_seen = state_reg.supply_meta;
		state_next.mode_meta = mode_pins;
		state_next.mode_sync = state_reg.mode_meta;

		// instruction-cycle enable pulse from the clock divider
		state_next.tcyc_tick = 1'b0;
		if (state_reg.tcyc_count == 32'(tcyc_cycles - 1)) begin
			state_next.tcyc_count = '0;
			state_next.tcyc_tick = 1'b1;
		end else begin
			state_next.tcyc_count = state_reg.tcyc_count + 32'd1;
		end

		if (state_reg.supply_seen && !state_reg.powered) begin
			state_next.powered = 1'b1; // rising supply only, no brown-out
			state_next.st = st_por;
			state_next.por_count = '0;
		end
		case (state_reg.st)
			st_por: begin
				if (state_reg.powered && state_reg.tcyc_tick) begin
					if (state_reg.por_count == 32'(por_delay - 1)) begin
						state_next.st = st_hold;
					end else begin
						state_next.por_count = state_reg.por_count + 32'd1;
					end
				end
			end
			st_hold: begin
				if (pin_n_sync) begin
					state_next.st = st_run; // first edge after synchronised pin release
				end
			end
			st_run: begin
				if (!pin_n_sync || wd_timeout) begin
					state_next.st = st_hold;
				end
			end
			default: state_next.st = st_hold;
		endcase
		if (state_reg.st != st_run) begin
			state_next.mask = 1'b1;
			state_next.vector = vec_reset;
			// watchdog reset leaves the latched mode untouched
			if (!state_reg.mode_latched && state_reg.st == st_hold && pin_n_sync) begin
				state_next.mode = state_reg.mode_sync;
				state_next.mode_latched = 1'b1;
			end
		end else if (instruction_end && software_trap) begin
			state_next.take = 1'b1; // trap ignores mask
			state_next.mask = 1'b1;
			state_next.vector = vec_software;
		end else if (instruction_end && win_valid && !state_reg.mask) begin
			state_next.take = 1'b1;
			state_next.mask = 1'b1;
			state_next.vector = win_vector;
		end else if (return_from_service) begin
			state_next.mask = stacked_mask;
		end
		if (!pin_n_sync) begin
			state_next.mode_latched = 1'b0; // external reset re-samples mode
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= '{
				st: st_por,
				por_count: 32'd0,
				tcyc_count: 32'd0,
				tcyc_tick: 1'b0,
				supply_meta: 1'b0,
				supply_seen: 1'b0,
				mode_meta: 2'b00,
				mode_sync: 2'b00,
				powered: 1'b0,
				mask: 1'b1,
				take: 1'b0,
				vector: vec_reset,
				mode: 2'b00,
				mode_latched: 1'b0
			};
		end else begin
			state_reg <= state_next;
		end
	end

	assign sys_reset = state_reg.st != st_run;
	assign operating_mode = state_reg.mode;
	assign interrupt_mask = state_reg.mask;
	assign service_take = state_reg.take;
	assign vector_address = state_reg.vector;
	assign stack_pointer_init = stack_pointer_reset;
	assign timer_counter_init = timer_counter_reset;
endmodule : reset_and_interrupt_control
`default_nettype wire

/* verif/reset_and_interrupt_control_sva.sv */
// assertion checker for reset sequencing and interrupt arbitration
`timescale 1ns/1ps
`default_nettype none
module rst_irq_sva
	import reset_irq_pkg::*;
#(
	parameter int por_delay = por_delay_tcyc,
	parameter int watchdog_cycles = 65536
) (
	input wire logic clock, srst, instruction_end, software_trap, return_from_service, stacked_mask,
	input wire logic mft_write, sys_reset, interrupt_mask, service_take, watchdog_enabled,
	input wire logic capture_flag, compare0_flag, compare1_flag, counter_overflow_flag,
	input wire logic capture_irq_enable, compare0_irq_enable, compare1_irq_enable, overflow_irq_enable,
	input wire logic [7:0] mft_write_data,
	input wire logic [15:0] vector_address, stack_pointer_init, timer_counter_init,
	input wire logic [hw_sources-1:0] source_request
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	sequence hw_boundary;
		instruction_end && !software_trap && !interrupt_mask && !sys_reset;
	endsequence
	sequence trap_boundary;
		instruction_end && software_trap && !sys_reset;
	endsequence
	AST_RESET_STATE: assert property (sys_reset [*2] |-> interrupt_mask && vector_address == vec_reset)
		else $error("reset state wrong");
	AST_INIT_CONST: assert property (stack_pointer_init == 16'h00FF && timer_counter_init == 16'hFFFC)
		else $error("init constants wrong");
	AST_WATCHDOG_ENABLE_BIT_OFF: assert property (sys_reset [*2] |-> !watchdog_enabled)
		else $error("watchdog on in reset");
	AST_WATCHDOG_ENABLE_BIT_ON: assert property (mft_write && mft_write_data[2] && !sys_reset ##1 !sys_reset [*2] |-> watchdog_enabled)
		else $error("watchdog not enabled");
	AST_TRAP_TAKEN: assert property (trap_boundary |=> service_take && interrupt_mask && vector_address == vec_software)
		else $error("trap not taken");
	AST_MASK_BLOCKS: assert property (instruction_end && !software_trap && interrupt_mask |=> !service_take)
		else $error("masked request taken");
	AST_DISPLAY_WINS: assert property (hw_boundary ##0 source_request[6] |=> service_take && vector_address == 16'hFFFA)
		else $error("display not first");
	AST_TIMER_VECTOR: assert property (hw_boundary ##0 source_request[6:4] == 3'b001 |=> vector_address == 16'hFFF6)
		else $error("timer vector wrong");
	AST_TIMER_OR: assert property (!sys_reset |-> !source_request[0] && source_request[4] == ((capture_flag && capture_irq_enable)
		|| (compare0_flag && compare0_irq_enable) || (compare1_flag && compare1_irq_enable)
		|| (counter_overflow_flag && overflow_irq_enable))) else $error("timer request wrong");
	AST_TAKE_PULSE: assert property (service_take |=> !service_take)
		else $error("take longer than one cycle");
	AST_RETURN_MASK: assert property (return_from_service && !sys_reset |=> interrupt_mask == $past(stacked_mask))
		else $error("mask not restored");
endmodule : rst_irq_sva
bind reset_and_interrupt_control rst_irq_sva #(.por_delay(por_delay), .watchdog_cycles(watchdog_cycles)) i_rst_irq_sva (.*);
`default_nettype wire

/* verif/cpu_partner.sv */
// behavioural cpu core: instruction boundaries, trap, return with stacked mask
`timescale 1ns/1ps
`default_nettype none
module cpu_partner (
	input wire logic clock,
	input wire logic srst,
	input wire logic do_step,
	input wire logic do_trap,
	input wire logic do_ret,
	input wire logic interrupt_mask,
	output logic instruction_end,
	output logic software_trap,
	output logic return_from_service,
	output logic stacked_mask
);
	logic saved_mask;
	always_ff @(posedge clock) begin
		instruction_end <= do_step;
		software_trap <= do_step & do_trap;
		return_from_service <= do_ret;
		if (srst) begin
			saved_mask <= 1'b0;
			stacked_mask <= 1'b0;
		end else begin
			// stack image taken before the take sets the mask
			if (instruction_end) begin
				saved_mask <= interrupt_mask;
			end
			// outside a return the line is meaningless, so it toggles
			stacked_mask <= do_ret ? saved_mask : ~stacked_mask;
		end
	end
endmodule : cpu_partner
`default_nettype wire

/* verif/tb.sv */
// testbench for reset sequencing and interrupt arbitration
`timescale 1ns/1ps
`default_nettype none
module tb;
	import reset_irq_pkg::*;
	localparam int por = 8;
	logic clock, srst, supply_rise, reset_pin_n, watchdog_service_write, watchdog_service_data, mft_write;
	logic instruction_end, software_trap, return_from_service, stacked_mask, do_step, do_trap, do_ret;
	logic sys_reset, interrupt_mask, service_take, watchdog_enabled;
	logic [1:0] mode_pins, operating_mode;
	logic [7:0] mft_write_data;
	logic [15:0] vector_address, stack_pointer_init, timer_counter_init, fl;
	logic [8:0] en;
	logic [6:0] source_request;
	int error_cnt, cmp_count, n;
	// trap, flags, enables, take, vector
	logic [42:0] rows [17] = '{{1'b1, 16'h0000, 9'h000, 1'b1, 16'hFFFC}, {1'b1, 16'hFFFF, 9'h1FF, 1'b1, 16'hFFFC},
		{1'b0, 16'hFFFF, 9'h1FF, 1'b1, 16'hFFFA}, {1'b0, 16'h0001, 9'h001, 1'b1, 16'hFFFA},
		{1'b0, 16'h0010, 9'h001, 1'b1, 16'hFFFA}, {1'b0, 16'h0010, 9'h000, 1'b0, 16'h0000},
		{1'b0, 16'h0020, 9'h000, 1'b1, 16'hFFF8}, {1'b0, 16'h0040, 9'h002, 1'b1, 16'hFFF6},
		{1'b0, 16'h0200, 9'h010, 1'b1, 16'hFFF6}, {1'b0, 16'h0200, 9'h002, 1'b0, 16'h0000},
		{1'b0, 16'h0400, 9'h020, 1'b1, 16'hFFF4}, {1'b0, 16'h1000, 9'h020, 1'b1, 16'hFFF4},
		{1'b0, 16'h2000, 9'h040, 1'b1, 16'hFFF2}, {1'b0, 16'h4000, 9'h080, 1'b1, 16'hFFF0},
		{1'b0, 16'h8000, 9'h100, 1'b1, 16'hFFF0}, {1'b0, 16'h8060, 9'h1FF, 1'b1, 16'hFFF8},
		{1'b0, 16'h0900, 9'h028, 1'b1, 16'hFFF6}};
	reset_and_interrupt_control #(.por_delay(por), .watchdog_cycles(16)) i_reset_and_interrupt_control (.*,
		.vertical_flyback_flag(fl[0]), .row0_done_flag(fl[1]), .row1_done_flag(fl[2]), .row2_done_flag(fl[3]),
		.row3_done_flag(fl[4]), .ext_request(fl[5]), .capture_flag(fl[6]), .compare0_flag(fl[7]),
		.compare1_flag(fl[8]), .counter_overflow_flag(fl[9]), .arbitration_lost_flag(fl[10]),
		.addressed_as_target_flag(fl[11]), .transfer_complete_flag(fl[12]), .accumulator_overflow_flag(fl[13]),
		.periodic_tick_flag(fl[14]), .mft_overflow_flag(fl[15]), .display_irq_enable(en[0]),
		.capture_irq_enable(en[1]), .compare0_irq_enable(en[2]), .compare1_irq_enable(en[3]),
		.overflow_irq_enable(en[4]), .serial_irq_enable(en[5]), .accumulator_irq_enable(en[6]),
		.periodic_irq_enable(en[7]), .mft_overflow_irq_enable(en[8]));
	cpu_partner i_cpu_partner (.*);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic final_report;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_rst(input logic lvl, input int lim);
		n = 0;
		while (sys_reset !== lvl && n < lim) begin
			@(posedge clock);
			#1 n++;
		end
		chk({15'h0000, sys_reset}, {15'h0000, lvl});
		if (sys_reset !== lvl) final_report();
	endtask : wait_rst
	task automatic step(input logic [42:0] r);
		@(posedge clock);
		do_step <= 1'b1;
		do_trap <= r[42];
		fl <= r[41:26];
		en <= r[25:17];
		@(posedge clock);
		do_step <= 1'b0;
		@(posedge clock);
		#1 chk({15'h0000, service_take}, {15'h0000, r[16]});
		if (r[16]) chk(vector_address, r[15:0]);
	endtask : step
	task automatic ret;
		@(posedge clock);
		do_ret <= 1'b1;
		fl <= '0;
		en <= '0;
		@(posedge clock);
		do_ret <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask : ret
	initial begin
		{srst, supply_rise, reset_pin_n, do_step, do_trap, do_ret} = 6'b101000;
		{watchdog_service_write, watchdog_service_data, mft_write, mft_write_data} = '0;
		{fl, en, error_cnt, cmp_count, mode_pins} = {25'h0, 32'h0, 32'h0, 2'b10};
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		repeat (20) @(posedge clock);
		#1 chk({sys_reset, interrupt_mask, watchdog_enabled}, 16'h0006);
		chk(vector_address, vec_reset);
		@(posedge clock);
		supply_rise <= 1'b1;
		@(posedge clock);
		supply_rise <= 1'b0;
		wait_rst(1'b0, por + 20);
		chk(16'(n >= por - 1), 16'h0001);
		foreach (rows[i]) begin
			ret();
			chk({15'h0000, interrupt_mask}, 16'h0000);
			step(rows[i]);
		end
		ret();
		fl <= 16'hFFFF;
		en <= 9'h1FF;
		@(posedge clock);
		#1 chk({9'h000, source_request}, 16'h007E);
		en <= '0;
		@(posedge clock);
		#1 chk({9'h000, source_request}, 16'h0020);
		step(rows[1]);
		step({1'b0, 16'hFFFF, 9'h1FF, 1'b0, 16'h0000});
		step(rows[0]);
		ret();
		chk({15'h0000, interrupt_mask}, 16'h0001);
		srst <= 1'b1;
		reset_pin_n <= 1'b0;
		repeat (3) @(posedge clock);
		{srst, supply_rise} <= 2'b01;
		@(posedge clock);
		supply_rise <= 1'b0;
		repeat (por + 10) @(posedge clock);
		#1 chk({15'h0000, sys_reset}, 16'h0001);
		reset_pin_n <= 1'b1;
		wait_rst(1'b0, 6);
		supply_rise <= 1'b1;
		repeat (3) @(posedge clock);
		supply_rise <= 1'b0;
		repeat (por + 4) @(posedge clock);
		#1 chk({15'h0000, sys_reset}, 16'h0000);
		{reset_pin_n, mode_pins} <= 3'b001;
		wait_rst(1'b1, 6);
		reset_pin_n <= 1'b1;
		wait_rst(1'b0, 8);
		{mft_write, mft_write_data} <= 9'h104;
		@(posedge clock);
		mft_write <= 1'b0;
		repeat (6) begin
			repeat (8) @(posedge clock);
			watchdog_service_write <= 1'b1;
			@(posedge clock);
			watchdog_service_write <= 1'b0;
			#1 chk({15'h0000, sys_reset}, 16'h0000);
		end
		{mft_write, mft_write_data, mode_pins} <= 11'h7EE;
		@(posedge clock);
		mft_write <= 1'b0;
		#1 chk({15'h0000, watchdog_enabled}, 16'h0001);
		wait_rst(1'b1, 40);
		repeat (2) @(posedge clock);
		#1 chk({15'h0000, watchdog_enabled}, 16'h0000);
		wait_rst(1'b0, por + 20);
		chk({14'h0000, operating_mode}, 16'h0001);
		final_report();
	end
endmodule : tb
`default_nettype wire
